// ===== hw/pfc_map.svh
// register offsets, field positions, reset values and timing counts for the flash controller
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH
// ----------------------------------------------------------------
// device register window, byte addresses on the cpu bus
// ----------------------------------------------------------------
`define PFC_LOCK_ADDR    16'h00f4
`define PFC_CFG_ADDR     16'h00f5
`define PFC_CTL_ADDR     16'h00f7
`define PFC_PAGE_ADDR    16'h0030
`define PFC_EEPROM_CONFIG_REGISTER_ADDR   16'h0013
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PFC_LOCK_BIT     0
`define PFC_CFG_BOOT_BLOCK_PROTECT    0
`define PFC_CTL_HALT     4
`define PFC_CTL_HV       3
`define PFC_CTL_ERS      1
`define PFC_CTL_PGM      0
`define PFC_EEPROM_CONFIG_REGISTER_UNLOCK 4
`define PFC_EEPROM_CONFIG_REGISTER_ONE    3
`define PFC_BOOT_BLOCK_PROTECT_RST    1'b1
`define PFC_ERASED       16'hffff
// ----------------------------------------------------------------
// timing, bus clock 10 MHz
// ----------------------------------------------------------------
`define PFC_CLK_MHZ      10
`define PFC_NVS_US       10
`define PFC_PGS_US       5
`define PFC_NVS_CYC      8'(`PFC_NVS_US * `PFC_CLK_MHZ)
`define PFC_PGS_CYC      8'(`PFC_PGS_US * `PFC_CLK_MHZ)
// ----------------------------------------------------------------
// host apb register offsets
// ----------------------------------------------------------------
`define PFC_H_ADDR       8'h00
`define PFC_H_WDATA      8'h04
`define PFC_H_CMD        8'h08
`define PFC_H_STAT       8'h0c
`define PFC_H_RDATA      8'h10
`define PFC_H_MODE       8'h14
`define PFC_CMD_GO       0
`define PFC_CMD_WE       1
`define PFC_CMD_WORD     2
`define PFC_MODE_WAIT    0
`define PFC_MODE_STOP    1
`define PFC_MODE_SPECIAL 2
`endif

// ===== hw/pfc_pkg.sv
// types used by the flash end of the controller
package pfc_pkg;
  typedef enum logic [3:0] {
    PFC_IDLE   = 4'b0001,
    PFC_ARMED  = 4'b0010,
    PFC_SETUP  = 4'b0100,
    PFC_ACTIVE = 4'b1000
  } pfc_state_t;
endpackage : pfc_pkg

// ===== hw/pfc_if.sv
// cpu bus between the host end and the flash device
`timescale 1ns/1ps
interface pfc_if;
  logic        req;
  logic        we;
  logic        word;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  logic        wait_mode;
  logic        stop_mode;
  logic        special_mode;
  modport dev  (input req, we, word, addr, wdata, wait_mode, stop_mode, special_mode,
                output rdata, ack);
  modport host (output req, we, word, addr, wdata, wait_mode, stop_mode, special_mode,
                input rdata, ack);
endinterface : pfc_if

// ===== hw/pfc_flash.sv
// four-array paged flash with program and erase sequencing
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "pfc_map.svh"
module pfc_flash (
  input  wire logic       pclk,
  input  wire logic       presetn,
  pfc_if.dev              bus,
  input  wire logic       shadow_unlock,
  output logic [3:0]      flash_clk_en,
  output logic            hv_pump_on
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]        mem [0:65535];
  logic [3:0]         lock_reg, boot_block_protect_reg, halt_reg, hv_reg, ers_reg, pgm_reg;
  logic [3:0]         lock_next, boot_block_protect_next, halt_next, hv_next, ers_next, pgm_next;
  logic [2:0]         page_reg;
  logic               unlock_reg, loaded_reg;
  pfc_pkg::pfc_state_t st_reg;
  logic [1:0]         op_reg;
  logic [8:0]         row_reg;
  logic [7:0]         cnt_reg;
  logic [13:0]        sweep_reg;
  logic               sweep_done_reg;
  logic               busy2_reg, ack_reg;
  logic [15:0]        rdata_reg;
  logic [15:0]        addr1;
  logic [17:0]        p0, p1;
  logic [7:0]         d, hi_reg;
  logic [1:0]         pg;
  logic               wr, wr_lock, wr_cfg, wr_ctl, wr_page, wr_ee, abort;
  logic               sel_op, latch_ok, prog_ok, sweep_en, hv_ok, in_op;

  // {hit, array, offset within array}
  function automatic logic [17:0] phys(input logic [15:0] a, input logic [2:0] pgs);
    case (a[15:14])
      2'b01:   phys = {1'b1, 2'd3, 1'b0, a[13:0]};
      2'b11:   phys = {1'b1, 2'd3, 1'b1, a[13:0]};
      2'b10:   phys = {1'b1, pgs, a[13:0]};
      default: phys = 18'h00000;
    endcase
  endfunction : phys

  function automatic logic [7:0] byte_of(input logic [17:0] p, input logic [15:0] a);
    logic [15:0] w;
    logic [7:0]  b;
    w = mem[p[16:1]];
    b = 8'h00;
    if (p[17]) begin
      b = p[0] ? w[7:0] : w[15:8];
    end else begin
      case (a)
        `PFC_LOCK_ADDR:  b[`PFC_LOCK_BIT] = lock_reg[pg];
        `PFC_CFG_ADDR:   b[`PFC_CFG_BOOT_BLOCK_PROTECT] = boot_block_protect_reg[pg];
        `PFC_CTL_ADDR: begin
          b[`PFC_CTL_HALT] = halt_reg[pg];
          b[`PFC_CTL_HV]   = hv_reg[pg];
          b[`PFC_CTL_ERS]  = ers_reg[pg];
          b[`PFC_CTL_PGM]  = pgm_reg[pg];
        end
        `PFC_PAGE_ADDR:  b[2:0] = page_reg;
        `PFC_EEPROM_CONFIG_REGISTER_ADDR: begin
          b[`PFC_EEPROM_CONFIG_REGISTER_UNLOCK] = unlock_reg;
          b[`PFC_EEPROM_CONFIG_REGISTER_ONE]    = 1'b1;
        end
        default:         b = 8'h00;
      endcase
    end
    return b;
  endfunction : byte_of

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign pg      = page_reg[2:1];
  assign addr1   = bus.addr + 16'h0001;
  assign p0      = phys(bus.addr, page_reg);
  assign p1      = phys(addr1, page_reg);
  assign d       = bus.wdata[7:0];
  assign wr      = bus.req & bus.we & ~busy2_reg;
  assign wr_lock = wr & (bus.addr == `PFC_LOCK_ADDR);
  assign wr_cfg  = wr & (bus.addr == `PFC_CFG_ADDR);
  assign wr_ctl  = wr & (bus.addr == `PFC_CTL_ADDR);
  assign wr_page = wr & (bus.addr == `PFC_PAGE_ADDR);
  assign wr_ee   = wr & (bus.addr == `PFC_EEPROM_CONFIG_REGISTER_ADDR);
  assign abort   = bus.wait_mode | bus.stop_mode;
  assign sel_op  = pgm_reg[op_reg] | ers_reg[op_reg];
  assign in_op   = wr & p0[17] & (p0[16:15] == op_reg) & unlock_reg;
  // selecting write: any address for erase, aligned word for program
  assign latch_ok = (st_reg == pfc_pkg::PFC_ARMED) & in_op
                  & (ers_reg[op_reg] | (bus.word & ~bus.addr[0]));
  assign hv_ok    = (st_reg == pfc_pkg::PFC_SETUP) & (cnt_reg >= `PFC_NVS_CYC)
                  & unlock_reg;
  // a program word lands only inside the latched row, never in a protected boot block
  assign prog_ok  = (st_reg == pfc_pkg::PFC_ACTIVE) & pgm_reg[op_reg] & hv_reg[op_reg]
                  & in_op & bus.word & ~bus.addr[0]
                  & (p0[14:6] == row_reg)
                  & (cnt_reg >= `PFC_PGS_CYC)
                  & ~(boot_block_protect_reg[op_reg] & (p0[14:13] == 2'b11));
  assign sweep_en = (st_reg == pfc_pkg::PFC_ACTIVE) & ers_reg[op_reg] & hv_reg[op_reg]
                  & ~sweep_done_reg & unlock_reg;

  // ----------------------------------------------------------------
  // per-array control page
  // ----------------------------------------------------------------
  for (genvar k = 0; k < 4; k++) begin : g_page
    logic wk;
    logic cw;
    assign wk = (pg == 2'(k));
    assign cw = wr_ctl & wk;
    assign pgm_next[k] = (cw & ~(d[`PFC_CTL_PGM] & d[`PFC_CTL_ERS])) ?
                         d[`PFC_CTL_PGM] : pgm_reg[k];
    assign ers_next[k] = (cw & ~(d[`PFC_CTL_PGM] & d[`PFC_CTL_ERS])) ?
                         d[`PFC_CTL_ERS] : ers_reg[k];
    assign hv_next[k]  = abort ? 1'b0 :
                         cw ? (d[`PFC_CTL_HV] & (hv_reg[k] | (hv_ok & (op_reg == 2'(k))
                              & (pgm_reg[k] | ers_reg[k])))) : hv_reg[k];
    assign halt_next[k]  = cw ? d[`PFC_CTL_HALT] : halt_reg[k];
    assign boot_block_protect_next[k] = (wr_cfg & wk & ~(lock_reg[k] | hv_reg[k] | pgm_reg[k] | ers_reg[k]))
                           ? d[`PFC_CFG_BOOT_BLOCK_PROTECT] : boot_block_protect_reg[k];
    assign lock_next[k]  = (wr_lock & wk) ? d[`PFC_LOCK_BIT] : lock_reg[k];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pgm_reg   <= 4'h0;
      ers_reg   <= 4'h0;
      hv_reg    <= 4'h0;
      halt_reg  <= 4'h0;
      boot_block_protect_reg <= {4{`PFC_BOOT_BLOCK_PROTECT_RST}};
      lock_reg  <= 4'h0;
    end else begin
      pgm_reg   <= pgm_next;
      ers_reg   <= ers_next;
      hv_reg    <= hv_next;
      halt_reg  <= halt_next;
      boot_block_protect_reg <= boot_block_protect_next;
      lock_reg  <= lock_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_reg <= 3'h0;
    end else if (wr_page) begin
      page_reg <= d[2:0];
    end
  end

  // shadow level is caught on the first edge after release, not by the reset itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_reg <= 1'b0;
      loaded_reg <= 1'b0;
    end else if (!loaded_reg) begin
      unlock_reg <= shadow_unlock;
      loaded_reg <= 1'b1;
    end else if (wr_ee & (bus.special_mode | ~d[`PFC_EEPROM_CONFIG_REGISTER_UNLOCK])) begin
      unlock_reg <= d[`PFC_EEPROM_CONFIG_REGISTER_UNLOCK];
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg         <= pfc_pkg::PFC_IDLE;
      op_reg         <= 2'd0;
      row_reg        <= 9'h000;
      cnt_reg        <= 8'h00;
      sweep_reg      <= 14'h0000;
      sweep_done_reg <= 1'b0;
    end else begin
      if (cnt_reg != 8'hff) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
      if (sweep_en) begin
        sweep_reg      <= sweep_reg + 14'h0001;
        sweep_done_reg <= (sweep_reg == 14'h3fff);
      end
      if (abort) begin
        st_reg <= pfc_pkg::PFC_IDLE;
      end else begin
        unique case (st_reg)
          pfc_pkg::PFC_IDLE: begin
            for (int i = 3; i >= 0; i--) begin
              if (pgm_reg[i] | ers_reg[i]) begin
                op_reg <= 2'(i);
              end
            end
            if (|(pgm_reg | ers_reg)) begin
              st_reg <= pfc_pkg::PFC_ARMED;
            end
          end
          pfc_pkg::PFC_ARMED: begin
            if (!sel_op) begin
              st_reg <= pfc_pkg::PFC_IDLE;
            end else if (latch_ok) begin
              row_reg        <= p0[14:6];
              cnt_reg        <= 8'h00;
              sweep_reg      <= 14'h0000;
              sweep_done_reg <= 1'b0;
              st_reg         <= pfc_pkg::PFC_SETUP;
            end
          end
          pfc_pkg::PFC_SETUP: begin
            if (!sel_op) begin
              st_reg <= pfc_pkg::PFC_IDLE;
            end else if (hv_reg[op_reg]) begin
              cnt_reg <= 8'h00;
              st_reg  <= pfc_pkg::PFC_ACTIVE;
            end
          end
          pfc_pkg::PFC_ACTIVE: begin
            if (!sel_op && !hv_reg[op_reg]) begin
              st_reg <= pfc_pkg::PFC_IDLE;
            end
          end
        endcase
      end
    end
  end

  // erased content is all ones from power-up; cells only lose ones when programmed
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = `PFC_ERASED;
    end
  end

  // low power entry cuts the cell write in the very same cycle
  always @(posedge pclk) begin
    if (prog_ok && !abort) begin
      mem[p0[16:1]] <= mem[p0[16:1]] & bus.wdata;
    end else if (sweep_en && !abort && !(boot_block_protect_reg[op_reg] && sweep_reg[13:12] == 2'b11)) begin
      mem[{op_reg, sweep_reg}] <= `PFC_ERASED;
    end
  end

  // ----------------------------------------------------------------
  // bus answer; a write outside the sequence only acks
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg   <= 1'b0;
      busy2_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      hi_reg    <= 8'h00;
    end else begin
      ack_reg <= 1'b0;
      if (busy2_reg) begin
        busy2_reg       <= 1'b0;
        ack_reg         <= 1'b1;
        rdata_reg       <= {hi_reg, byte_of(p1, addr1)};
      end else if (bus.req) begin
        if (!bus.we && bus.word && bus.addr[0]) begin
          // high byte parked so read data only moves together with ack
          busy2_reg       <= 1'b1;
          hi_reg          <= byte_of(p0, bus.addr);
        end else begin
          ack_reg <= 1'b1;
          if (!bus.we) begin
            rdata_reg <= bus.word ? {byte_of(p0, bus.addr), byte_of(p1, addr1)}
                                  : {8'h00, byte_of(p0, bus.addr)};
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_clk_en <= 4'hf;
      hv_pump_on   <= 1'b0;
    end else begin
      flash_clk_en <= ~({4{bus.wait_mode}} & halt_reg);
      hv_pump_on   <= |hv_reg;
    end
  end

  assign bus.ack   = ack_reg;
  assign bus.rdata = rdata_reg;
endmodule : pfc_flash

// ===== hw/pfc_host.sv
// apb-commanded bus master that drives the flash device's cpu bus
`timescale 1ns/1ps
`include "pfc_map.svh"
module pfc_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  pfc_if.host              bus
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] addr_reg, wdata_reg, rdata_reg;
  logic        we_reg, word_reg, req_reg, busy_reg;
  logic [2:0]  mode_reg;
  logic        acc, hit;
  logic [31:0] rd_val;

  assign acc = psel & penable & pready & pwrite;
  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h00000000;
    case (paddr)
      `PFC_H_ADDR:  rd_val = {16'h0000, addr_reg};
      `PFC_H_WDATA: rd_val = {16'h0000, wdata_reg};
      `PFC_H_CMD:   rd_val = {29'h0, word_reg, we_reg, 1'b0};
      `PFC_H_STAT:  rd_val = {31'h0, busy_reg};
      `PFC_H_RDATA: rd_val = {16'h0000, rdata_reg};
      `PFC_H_MODE:  rd_val = {29'h0, mode_reg};
      default:      hit    = 1'b0;
    endcase
  end

  // zero-wait slave: ready rises for the access cycle that follows each setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h00000000 : rd_val;
      end
    end
  end

  // address and data are frozen while a transfer is outstanding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg  <= 16'h0000;
      wdata_reg <= 16'h0000;
      mode_reg  <= 3'h0;
    end else if (acc) begin
      if (paddr == `PFC_H_ADDR && !busy_reg) begin
        addr_reg <= pwdata[15:0];
      end
      if (paddr == `PFC_H_WDATA && !busy_reg) begin
        wdata_reg <= pwdata[15:0];
      end
      if (paddr == `PFC_H_MODE) begin
        mode_reg <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      we_reg    <= 1'b0;
      word_reg  <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      req_reg <= 1'b0;
      if (busy_reg && !req_reg && bus.ack) begin
        busy_reg <= 1'b0;
        if (!we_reg) begin
          rdata_reg <= bus.rdata;
        end
      end else if (acc && paddr == `PFC_H_CMD && pwdata[`PFC_CMD_GO] && !busy_reg) begin
        req_reg  <= 1'b1;
        busy_reg <= 1'b1;
        we_reg   <= pwdata[`PFC_CMD_WE];
        word_reg <= pwdata[`PFC_CMD_WORD];
      end
    end
  end

  assign bus.req          = req_reg;
  assign bus.we           = we_reg;
  assign bus.word         = word_reg;
  assign bus.addr         = addr_reg;
  assign bus.wdata        = wdata_reg;
  assign bus.wait_mode    = mode_reg[`PFC_MODE_WAIT];
  assign bus.stop_mode    = mode_reg[`PFC_MODE_STOP];
  assign bus.special_mode = mode_reg[`PFC_MODE_SPECIAL];
endmodule : pfc_host

// ===== test/pfc_asserts.sv
// concurrent checks on the cpu bus between the host end and the flash end
`timescale 1ns/1ps
module pfc_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        req,
  input wire logic        we,
  input wire logic        word,
  input wire logic [15:0] addr,
  input wire logic [15:0] rdata,
  input wire logic        ack,
  input wire logic        wait_mode,
  input wire logic        stop_mode,
  input wire logic [3:0]  flash_clk_en,
  input wire logic        hv_pump_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // bus timing
  // ----------------------------------------------------------------
  property p_rd_fast;
    req && !we && (!word || !addr[0]) |=> ack;
  endproperty
  a_rd_fast: assert property (p_rd_fast) else $error("short read late");
  property p_rd_slow;
    req && !we && word && addr[0] |=> !ack ##1 ack;
  endproperty
  a_rd_slow: assert property (p_rd_slow) else $error("misaligned read timing");
  property p_wr_ack;
    req && we |=> ack;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write not acknowledged");
  property p_ack_src;
    ack |-> $past(req) || $past(req, 2);
  endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack without request");
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
  property p_rdata_hold;
    !ack |-> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_req_hold;
    req |=> !req && $stable(addr) && $stable(we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request not held");
  // ----------------------------------------------------------------
  // low power and reset
  // ----------------------------------------------------------------
  property p_clk_run;
    !wait_mode |=> flash_clk_en == 4'hf;
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("flash clock stopped");
  property p_abort;
    wait_mode || stop_mode |-> ##2 !hv_pump_on;
  endproperty
  a_abort: assert property (p_abort) else $error("pump kept on in low power");
  property p_rst_quiet;
    $rose(presetn) |-> (!hv_pump_on && !ack) [*8];
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("activity after reset");
endmodule : pfc_asserts

// ===== test/tb_top.sv
// self-checking bench: host and flash ends joined over the cpu bus
`timescale 1ns/1ps
`include "pfc_map.svh"
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        shadow_unlock;
  logic [3:0]  flash_clk_en;
  logic        hv_pump_on;
  logic [31:0] rd;
  logic [31:0] mq;
  logic        err;
  logic        rd_pend;
  logic [15:0] a_r;
  logic [15:0] d_r;
  logic        w_r;
  logic [31:0] exp_q[$];
  int          bad_count;
  int          tests_run;
  int          cyc;
  localparam logic [15:0] CTL = `PFC_CTL_ADDR;
  localparam logic [15:0] CFG = `PFC_CFG_ADDR;
  localparam logic [15:0] EEM = `PFC_EEPROM_CONFIG_REGISTER_ADDR;
  pfc_if bus ();
  pfc_host pfc_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus.host));
  pfc_flash pfc_flash_i (.pclk(pclk), .presetn(presetn), .bus(bus.dev),
    .shadow_unlock(shadow_unlock), .flash_clk_en(flash_clk_en), .hv_pump_on(hv_pump_on));
  pfc_asserts pfc_asserts_i (.pclk(pclk), .presetn(presetn), .req(bus.req), .we(bus.we),
    .word(bus.word), .addr(bus.addr), .rdata(bus.rdata), .ack(bus.ack),
    .wait_mode(bus.wait_mode), .stop_mode(bus.stop_mode), .flash_clk_en(flash_clk_en),
    .hv_pump_on(hv_pump_on));
  // ----------------------------------------------------------------
  // compare, report and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask : tdone
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one cpu bus transfer through the host, polled until no longer busy
  task automatic dev(input logic w, input logic wd, input logic [15:0] a,
                     input logic [15:0] d);
    apb(1'b1, `PFC_H_ADDR, a);
    apb(1'b1, `PFC_H_WDATA, d);
    apb(1'b1, `PFC_H_CMD, {13'h0000, wd, w, 1'b1});
    rd = 32'h00000001;
    while (rd[0] !== 1'b0) apb(1'b0, `PFC_H_STAT, 16'h0000);
  endtask : dev
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    dev(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rdc(input logic wd, input logic [15:0] a, input logic [15:0] m,
                     input logic [15:0] e);
    exp_q.push_back({m, e});
    dev(1'b0, wd, a, 16'h0000);
  endtask : rdc
  task automatic arm(input logic [15:0] a, input logic [15:0] c);
    wr(CTL, 16'h0001);
    dev(1'b1, 1'b1, a, 16'h0000);
    repeat (100) @(posedge pclk);
    wr(CTL, c);
  endtask : arm
  task automatic ends();
    wr(CTL, 16'h0008);
    repeat (50) @(posedge pclk);
    wr(CTL, 16'h0000);
    repeat (10) @(posedge pclk);
  endtask : ends
  // ----------------------------------------------------------------
  // clock, monitor and hang guard
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // sampled mid-cycle so ack and read data are settled
  always @(negedge pclk) begin
    if (bus.ack && rd_pend) begin
      mq = exp_q.pop_front();
      chk(bus.rdata & mq[31:16], mq[15:0]);
    end
    if (bus.req) rd_pend = !bus.we;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    shadow_unlock = 1'b1;
    rd_pend = 1'b0;
    bad_count = 0;
    tests_run = 0;
    cyc = 0;
    void'($urandom(32'haf724e12));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b1, 8'h18, 16'h0000);
    chk({15'h0000, err}, 16'h0001);
    rdc(1'b0, CTL, 16'h000b, 16'h0000);
    rdc(1'b0, CFG, 16'h0001, 16'h0001);
    rdc(1'b0, EEM, 16'h0018, 16'h0018);
    tdone("reset");
    for (int i = 0; i < 6; i++) begin
      a_r = 16'h4000 + 16'($urandom_range(16383));
      w_r = 1'($urandom);
      rdc(w_r, a_r, 16'hffff, w_r ? 16'hffff : 16'h00ff);
    end
    rdc(1'b1, 16'h7fff, 16'hffff, 16'hffff);
    dev(1'b1, 1'b1, 16'h4010, 16'h1234);
    rdc(1'b1, 16'h4010, 16'hffff, 16'hffff);
    tdone("read");
    wr(CTL, 16'h0003);
    rdc(1'b0, CTL, 16'h0003, 16'h0000);
    wr(CTL, 16'h0001);
    wr(CTL, 16'h0003);
    rdc(1'b0, CTL, 16'h0003, 16'h0001);
    wr(CTL, 16'h0009);
    rdc(1'b0, CTL, 16'h000b, 16'h0001);
    wr(CFG, 16'h0000);
    rdc(1'b0, CFG, 16'h0001, 16'h0001);
    wr(CTL, 16'h0002);
    rdc(1'b0, CTL, 16'h0003, 16'h0002);
    wr(CTL, 16'h0000);
    wr(`PFC_LOCK_ADDR, 16'h0001);
    wr(CFG, 16'h0000);
    rdc(1'b0, CFG, 16'h0001, 16'h0001);
    wr(`PFC_LOCK_ADDR, 16'h0000);
    tdone("interlock");
    arm(16'h8040, 16'h0009);
    chk({15'h0000, hv_pump_on}, 16'h0001);
    repeat (60) @(posedge pclk);
    d_r = 16'($urandom);
    dev(1'b1, 1'b1, 16'h8040, 16'h1234);
    repeat (300) @(posedge pclk);
    dev(1'b1, 1'b1, 16'h8042, d_r);
    repeat (300) @(posedge pclk);
    dev(1'b1, 1'b1, 16'h8080, 16'h0000);
    repeat (300) @(posedge pclk);
    ends();
    rdc(1'b1, 16'h8040, 16'hffff, 16'h1234);
    rdc(1'b1, 16'h8042, 16'hffff, d_r);
    rdc(1'b1, 16'h8080, 16'hffff, 16'hffff);
    rdc(1'b0, 16'h8041, 16'hffff, 16'h0034);
    wr(`PFC_PAGE_ADDR, 16'h0002);
    rdc(1'b1, 16'h8040, 16'hffff, 16'hffff);
    wr(`PFC_PAGE_ADDR, 16'h0000);
    tdone("program");
    // page 1 puts 0xa000 in the boot block of the first array
    wr(CFG, 16'h0000);
    wr(`PFC_PAGE_ADDR, 16'h0001);
    arm(16'ha000, 16'h0009);
    repeat (60) @(posedge pclk);
    dev(1'b1, 1'b1, 16'ha000, 16'h00f0);
    repeat (300) @(posedge pclk);
    ends();
    wr(CFG, 16'h0001);
    arm(16'ha000, 16'h0009);
    repeat (60) @(posedge pclk);
    dev(1'b1, 1'b1, 16'ha002, 16'h0000);
    repeat (300) @(posedge pclk);
    ends();
    rdc(1'b1, 16'ha000, 16'hffff, 16'h00f0);
    rdc(1'b1, 16'ha002, 16'hffff, 16'hffff);
    wr(`PFC_PAGE_ADDR, 16'h0000);
    tdone("boot");
    wr(CTL, 16'h0002);
    dev(1'b1, 1'b0, 16'h9001, 16'h0055);
    repeat (100) @(posedge pclk);
    wr(CTL, 16'h000a);
    // the sweep takes one cycle per word of the array
    repeat (16500) @(posedge pclk);
    ends();
    rdc(1'b1, 16'h8040, 16'hffff, 16'hffff);
    rdc(1'b1, 16'h8042, 16'hffff, 16'hffff);
    wr(`PFC_PAGE_ADDR, 16'h0001);
    rdc(1'b1, 16'ha000, 16'hffff, 16'h00f0);
    wr(`PFC_PAGE_ADDR, 16'h0000);
    tdone("erase");
    wr(EEM, 16'h0000);
    wr(EEM, 16'h0010);
    rdc(1'b0, EEM, 16'h0010, 16'h0000);
    arm(16'h8040, 16'h0009);
    rdc(1'b0, CTL, 16'h000b, 16'h0001);
    wr(CTL, 16'h0000);
    apb(1'b1, `PFC_H_MODE, 16'h0004);
    wr(EEM, 16'h0010);
    rdc(1'b0, EEM, 16'h0010, 16'h0010);
    tdone("unlock");
    arm(16'h8040, 16'h0019);
    chk({15'h0000, hv_pump_on}, 16'h0001);
    wr(`PFC_PAGE_ADDR, 16'h0002);
    rdc(1'b0, CTL, 16'h001b, 16'h0000);
    wr(`PFC_PAGE_ADDR, 16'h0000);
    apb(1'b1, `PFC_H_MODE, 16'h0001);
    repeat (3) @(posedge pclk);
    chk({15'h0000, hv_pump_on}, 16'h0000);
    chk({12'h000, flash_clk_en}, 16'h000e);
    apb(1'b1, `PFC_H_MODE, 16'h0000);
    repeat (3) @(posedge pclk);
    chk({12'h000, flash_clk_en}, 16'h000f);
    wr(CTL, 16'h0000);
    tdone("wait");
    arm(16'h8040, 16'h0009);
    chk({15'h0000, hv_pump_on}, 16'h0001);
    apb(1'b1, `PFC_H_MODE, 16'h0002);
    repeat (3) @(posedge pclk);
    chk({15'h0000, hv_pump_on}, 16'h0000);
    apb(1'b1, `PFC_H_MODE, 16'h0001);
    repeat (3) @(posedge pclk);
    chk({12'h000, flash_clk_en}, 16'h000f);
    apb(1'b1, `PFC_H_MODE, 16'h0000);
    wr(CTL, 16'h0000);
    tdone("stop");
    summarize();
  end
endmodule : tb_top
